// ==== bbas_defs.vh ====
// Constants for the add/subtract execution unit.
// Assumes inclusion by bbas_unit.v and by the checker and the bench; definitions only.
`ifndef BBAS_DEFS_VH
`define BBAS_DEFS_VH

// Function codes, 10-bit binary of the decimal instruction number
`define BBAS_FC_W 10
`define BBAS_FC_ADD 10'h190
`define BBAS_FC_ADD_DOUBLE 10'h191
`define BBAS_FC_ADD_CARRY 10'h192
`define BBAS_FC_BIN_ADD_CARRY_DOUBLE 10'h193
`define BBAS_FC_DEC_ADD 10'h194
`define BBAS_FC_DEC_ADD_DOUBLE 10'h195
`define BBAS_FC_DEC_ADD_CARRY_SINGLE 10'h196
`define BBAS_FC_DEC_ADD_CARRY_DOUBLE 10'h197
`define BBAS_FC_SUB 10'h19A
`define BBAS_FC_SUB_DOUBLE 10'h19B
`define BBAS_FC_SUB_CARRY 10'h19C
`define BBAS_FC_BIN_SUB_CARRY_DOUBLE 10'h19D
`define BBAS_FC_DEC_SUB 10'h19E
`define BBAS_FC_DEC_SUB_DOUBLE 10'h19F
`define BBAS_FC_DEC_SUB_CARRY_SINGLE 10'h1A0
`define BBAS_FC_DEC_SUB_CARRY_DOUBLE 10'h1A1

// Reset values
`define BBAS_RST_WORD 16'h0000
`define BBAS_RST_FLAG 1'b0

`endif

// ==== bbas_unit.v ====
// Binary and BCD add/subtract unit for the controller CPU.
// Assumes the sequencer presents code, operands and condition for one
// cycle with exec_i high, synchronous to mclk_i.
`timescale 1ns/1ns
`include "bbas_defs.vh"

// Function
// [RULE1] Code 400: 16-bit binary add, carry flag set on carry out.
// [RULE2] Code 401: 32-bit binary add of word pairs, carry flag on carry out.
// [RULE3] Code 402: 16-bit binary add with carry flag as carry-in.
// [RULE4] Code 403: 32-bit binary add with carry flag as carry-in.
// [RULE5] Code 404: four-digit BCD add, carry flag on decimal carry.
// [RULE6] Code 405: eight-digit BCD add of word pairs, decimal carry out.
// [RULE7] Code 406: four-digit BCD add with carry flag as carry-in.
// [RULE8] Code 407: eight-digit BCD add with carry flag as carry-in.
// [RULE9] Code 410: 16-bit binary subtract, carry flag on borrow.
// [RULE10] Code 411: 32-bit binary subtract of word pairs, flag on borrow.
// [RULE11] Code 412: 16-bit binary subtract with carry flag as borrow-in.
// [RULE12] Code 413: 32-bit binary subtract with carry flag as borrow-in.
// [RULE13] Code 414: four-digit BCD subtract, flag on borrow.
// [RULE14] Code 415: eight-digit BCD subtract of word pairs, flag on borrow.
// [RULE15] Code 416: four-digit BCD subtract with carry flag as borrow-in.
// [RULE16] Double forms: low half in named word, high half in next word.
// [RULE17] Operands may be memory words or constants; treated alike.
// [RULE18] Carry flag cleared when an operation has no carry or borrow.
// [RULE19] Results and flag change only when execution condition is true.
// [RULE20] Code 417: eight-digit BCD subtract with carry flag as borrow-in.
module bbas_unit (
    // Clock and reset
    input wire mclk_i,
    input wire sys_rst_i,
    // Instruction from sequencer
    input wire exec_i,
    input wire cond_i,
    input wire [`BBAS_FC_W-1:0] func_i,
    // Operands: first word and following word
    input wire [15:0] op_a_lo_i,
    input wire [15:0] op_a_hi_i,
    input wire [15:0] op_b_lo_i,
    input wire [15:0] op_b_hi_i,
    // Results
    output reg [15:0] res_lo_o,
    output reg [15:0] res_hi_o,
    output reg res_hi_we_o,
    output reg done_o,
    output reg carry_flag_o
);

    // Decimal digit add with carry; result is {carry, digit}
    function [4:0] bbas_dig_add;
        input [3:0] a;
        input [3:0] b;
        input cin;
        reg [4:0] s;
        begin
            s = {1'b0, a} + {1'b0, b} + {4'h0, cin};
            if (s > 5'h09) begin
                s = s + 5'h06;
                bbas_dig_add = {1'b1, s[3:0]};
            end else begin
                bbas_dig_add = s;
            end
        end
    endfunction

    // Decimal digit subtract with borrow; result is {borrow, digit}
    function [4:0] bbas_dig_sub;
        input [3:0] a;
        input [3:0] b;
        input bin;
        reg [4:0] d;
        begin
            d = {1'b0, a} - {1'b0, b} - {4'h0, bin};
            if (d[4]) begin
                d = d - 5'h06;
                bbas_dig_sub = {1'b1, d[3:0]};
            end else begin
                bbas_dig_sub = d;
            end
        end
    endfunction

    // Code decode, shared by validity, width and carry-in select
    function [3:0] bbas_decode;
        input [`BBAS_FC_W-1:0] fc;
        begin
            // {valid, double, decimal, use_carry} packed with subtract below
            case (fc)
                `BBAS_FC_ADD: bbas_decode = 4'h8;
                `BBAS_FC_ADD_DOUBLE: bbas_decode = 4'hC;
                `BBAS_FC_ADD_CARRY: bbas_decode = 4'h9;
                `BBAS_FC_BIN_ADD_CARRY_DOUBLE: bbas_decode = 4'hD;
                `BBAS_FC_DEC_ADD: bbas_decode = 4'hA;
                `BBAS_FC_DEC_ADD_DOUBLE: bbas_decode = 4'hE;
                `BBAS_FC_DEC_ADD_CARRY_SINGLE: bbas_decode = 4'hB;
                `BBAS_FC_DEC_ADD_CARRY_DOUBLE: bbas_decode = 4'hF;
                `BBAS_FC_SUB: bbas_decode = 4'h8;
                `BBAS_FC_SUB_DOUBLE: bbas_decode = 4'hC;
                `BBAS_FC_SUB_CARRY: bbas_decode = 4'h9;
                `BBAS_FC_BIN_SUB_CARRY_DOUBLE: bbas_decode = 4'hD;
                `BBAS_FC_DEC_SUB: bbas_decode = 4'hA;
                `BBAS_FC_DEC_SUB_DOUBLE: bbas_decode = 4'hE;
                `BBAS_FC_DEC_SUB_CARRY_SINGLE: bbas_decode = 4'hB;
                `BBAS_FC_DEC_SUB_CARRY_DOUBLE: bbas_decode = 4'hF;
                default: bbas_decode = 4'h0;
            endcase
        end
    endfunction

    wire [3:0] dec_bits;
    wire op_valid;
    wire op_double;
    wire op_use_carry;
    wire cin;

    assign dec_bits = bbas_decode(func_i);
    assign op_valid = dec_bits[3];
    assign op_double = dec_bits[2];
    assign op_use_carry = dec_bits[0];
    // [RULE3] [RULE4] [RULE7] [RULE8] [RULE11] [RULE12] [RULE15] [RULE20]
    assign cin = op_use_carry & carry_flag_o;

    // Operand words joined low-first; source of a word is not visible here
    wire [31:0] a_full;
    wire [31:0] b_full;
    assign a_full = {op_a_hi_i, op_a_lo_i}; // [RULE16] [RULE17]
    assign b_full = {op_b_hi_i, op_b_lo_i}; // [RULE16]

    // Binary path
    wire [32:0] bin_add32;
    wire [32:0] bin_sub32;
    wire [16:0] bin_add16;
    wire [16:0] bin_sub16;
    assign bin_add32 = {1'b0, a_full} + {1'b0, b_full} + {32'h0, cin}; // [RULE2] [RULE4]
    assign bin_sub32 = {1'b0, a_full} - {1'b0, b_full} - {32'h0, cin}; // [RULE10] [RULE12]
    assign bin_add16 = {1'b0, op_a_lo_i} + {1'b0, op_b_lo_i} + {16'h0, cin}; // [RULE1] [RULE3]
    assign bin_sub16 = {1'b0, op_a_lo_i} - {1'b0, op_b_lo_i} - {16'h0, cin}; // [RULE9] [RULE11]

    // Decimal ripple chains over eight digits
    wire [8:0] dadd_c;
    wire [8:0] dsub_c;
    wire [31:0] dadd_s;
    wire [31:0] dsub_s;
    assign dadd_c[0] = cin;
    assign dsub_c[0] = cin;
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : dig
            wire [4:0] ad;
            wire [4:0] sd;
            assign ad = bbas_dig_add(a_full[4*g+3:4*g], b_full[4*g+3:4*g], dadd_c[g]); // [RULE5] [RULE6]
            assign sd = bbas_dig_sub(a_full[4*g+3:4*g], b_full[4*g+3:4*g], dsub_c[g]); // [RULE13] [RULE14]
            assign dadd_s[4*g+3:4*g] = ad[3:0];
            assign dadd_c[g+1] = ad[4];
            assign dsub_s[4*g+3:4*g] = sd[3:0];
            assign dsub_c[g+1] = sd[4];
        end
    endgenerate

    // Result select, one branch per code; carry-in already folded into cin
    reg [31:0] next_res;
    reg next_carry;
    always @* begin
        next_res = 32'h0;
        next_carry = 1'b0;
        case (func_i)
            `BBAS_FC_ADD: begin
                next_res = {16'h0, bin_add16[15:0]}; // [RULE1]
                next_carry = bin_add16[16];
            end
            `BBAS_FC_ADD_DOUBLE: begin
                next_res = bin_add32[31:0]; // [RULE2]
                next_carry = bin_add32[32];
            end
            `BBAS_FC_ADD_CARRY: begin
                next_res = {16'h0, bin_add16[15:0]}; // [RULE3]
                next_carry = bin_add16[16];
            end
            `BBAS_FC_BIN_ADD_CARRY_DOUBLE: begin
                next_res = bin_add32[31:0]; // [RULE4]
                next_carry = bin_add32[32];
            end
            `BBAS_FC_DEC_ADD: begin
                next_res = {16'h0, dadd_s[15:0]}; // [RULE5]
                next_carry = dadd_c[4];
            end
            `BBAS_FC_DEC_ADD_DOUBLE: begin
                next_res = dadd_s; // [RULE6]
                next_carry = dadd_c[8];
            end
            `BBAS_FC_DEC_ADD_CARRY_SINGLE: begin
                next_res = {16'h0, dadd_s[15:0]}; // [RULE7]
                next_carry = dadd_c[4];
            end
            `BBAS_FC_DEC_ADD_CARRY_DOUBLE: begin
                next_res = dadd_s; // [RULE8]
                next_carry = dadd_c[8];
            end
            `BBAS_FC_SUB: begin
                next_res = {16'h0, bin_sub16[15:0]}; // [RULE9]
                next_carry = bin_sub16[16];
            end
            `BBAS_FC_SUB_DOUBLE: begin
                next_res = bin_sub32[31:0]; // [RULE10]
                next_carry = bin_sub32[32];
            end
            `BBAS_FC_SUB_CARRY: begin
                next_res = {16'h0, bin_sub16[15:0]}; // [RULE11]
                next_carry = bin_sub16[16];
            end
            `BBAS_FC_BIN_SUB_CARRY_DOUBLE: begin
                next_res = bin_sub32[31:0]; // [RULE12]
                next_carry = bin_sub32[32];
            end
            `BBAS_FC_DEC_SUB: begin
                next_res = {16'h0, dsub_s[15:0]}; // [RULE13]
                next_carry = dsub_c[4];
            end
            `BBAS_FC_DEC_SUB_DOUBLE: begin
                next_res = dsub_s; // [RULE14]
                next_carry = dsub_c[8];
            end
            `BBAS_FC_DEC_SUB_CARRY_SINGLE: begin
                next_res = {16'h0, dsub_s[15:0]}; // [RULE15]
                next_carry = dsub_c[4];
            end
            `BBAS_FC_DEC_SUB_CARRY_DOUBLE: begin
                next_res = dsub_s; // [RULE20]
                next_carry = dsub_c[8];
            end
            default: begin
                next_res = 32'h0;
                next_carry = 1'b0;
            end
        endcase
    end

    // Unknown codes and false conditions leave results and flag untouched
    wire do_exec;
    assign do_exec = exec_i & cond_i & op_valid; // [RULE19]

    // One-cycle completion pulse per executed instruction
    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            done_o <= 1'b0;
        end else begin
            done_o <= do_exec; // [RULE19]
        end
    end

    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            res_lo_o <= `BBAS_RST_WORD;
        end else if (do_exec) begin
            res_lo_o <= next_res[15:0];
        end
    end

    // Single forms load zero here; the store ignores it via res_hi_we_o
    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            res_hi_o <= `BBAS_RST_WORD;
        end else if (do_exec) begin
            res_hi_o <= next_res[31:16]; // [RULE16]
        end
    end

    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            res_hi_we_o <= 1'b0;
        end else if (do_exec) begin
            res_hi_we_o <= op_double; // [RULE16]
        end
    end

    // Written both ways so a quiet operation clears it
    always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            carry_flag_o <= `BBAS_RST_FLAG;
        end else if (do_exec) begin
            carry_flag_o <= next_carry; // [RULE18]
        end
    end

endmodule

// ==== bbas_store.sv ====
// Result store of the sequencer's data memory: word R and word R+1.
// Assumes done_i, we_hi_i and the result words come from the unit.
`timescale 1ns/1ns
module bbas_store (
    // Clock
    input wire mclk_i,
    // Results from the unit
    input wire done_i,
    input wire we_hi_i,
    input wire [15:0] lo_i,
    input wire [15:0] hi_i,
    // Stored words
    output reg [15:0] word_r_o,
    output reg [15:0] word_r1_o
);
    // Operands reach the unit as plain words whatever their source
    always @(posedge mclk_i) begin
        if (done_i) begin
            word_r_o <= lo_i;
            // High half only for double forms; a single op leaves R+1 alone
            if (we_hi_i) begin
                word_r1_o <= hi_i;
            end
        end
    end
endmodule

// ==== bbas_unit_asserts.sv ====
// Port checks of the add/subtract unit.
// Assumes bbas_defs.vh on the include path; bound into bbas_unit.
`timescale 1ns/1ns
`include "bbas_defs.vh"
module bbas_unit_chk (
    input wire mclk_i,
    input wire sys_rst_i,
    input wire exec_i,
    input wire cond_i,
    input wire [`BBAS_FC_W-1:0] func_i,
    input wire [15:0] op_a_lo_i,
    input wire [15:0] op_a_hi_i,
    input wire [15:0] op_b_lo_i,
    input wire [15:0] op_b_hi_i,
    input wire [15:0] res_lo_o,
    input wire [15:0] res_hi_o,
    input wire res_hi_we_o,
    input wire done_o,
    input wire carry_flag_o
);
    wire go = exec_i && cond_i;
    // Codes 408 and 409 are holes in the range
    wire ok = func_i >= `BBAS_FC_ADD && func_i <= `BBAS_FC_DEC_SUB_CARRY_DOUBLE && func_i[9:1] != 9'h0CC;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    AST_DONE: assert property (go && ok |=> done_o) else $error("done missing");
    AST_REFUSE: assert property (!(go && ok) |=> !done_o && $stable(res_lo_o) && $stable(carry_flag_o))
        else $error("state changed without execution");
    AST_HI_WE: assert property (go && ok |=> res_hi_we_o == $past(func_i[0]) && (res_hi_we_o || res_hi_o == 16'h0000))
        else $error("high word enable wrong");
    AST_ADD16: assert property (go && func_i == `BBAS_FC_ADD |=> {carry_flag_o, res_lo_o} == $past({1'b0, op_a_lo_i} + op_b_lo_i))
        else $error("add wrong");
    AST_ADC16: assert property (go && func_i == `BBAS_FC_ADD_CARRY |=>
        {carry_flag_o, res_lo_o} == $past({1'b0, op_a_lo_i} + op_b_lo_i + carry_flag_o)) else $error("add carry wrong");
    AST_ADD32: assert property (go && func_i == `BBAS_FC_ADD_DOUBLE |=>
        {carry_flag_o, res_hi_o, res_lo_o} == $past({1'b0, op_a_hi_i, op_a_lo_i} + {op_b_hi_i, op_b_lo_i}))
        else $error("double add wrong");
    AST_SUB16: assert property (go && func_i == `BBAS_FC_SUB |=> {carry_flag_o, res_lo_o} == $past({1'b0, op_a_lo_i} - op_b_lo_i))
        else $error("subtract wrong");
    AST_SBC32: assert property (go && func_i == `BBAS_FC_BIN_SUB_CARRY_DOUBLE |=> {carry_flag_o, res_hi_o, res_lo_o} ==
        $past({1'b0, op_a_hi_i, op_a_lo_i} - {op_b_hi_i, op_b_lo_i} - carry_flag_o)) else $error("double sub wrong");
    COV_CARRY: cover property (go && func_i == `BBAS_FC_ADD ##1 carry_flag_o);
    COV_B2B: cover property (go && ok ##1 go && ok);
    COV_REFUSE: cover property (exec_i && !cond_i);
endmodule
bind bbas_unit bbas_unit_chk u_chk (.mclk_i, .sys_rst_i, .exec_i, .cond_i, .func_i, .op_a_lo_i, .op_a_hi_i,
    .op_b_lo_i, .op_b_hi_i, .res_lo_o, .res_hi_o, .res_hi_we_o, .done_o, .carry_flag_o);

// ==== tb.sv ====
// Self-checking bench of the add/subtract unit with its result store.
// Assumes bbas_defs.vh on the include path.
`timescale 1ns/1ns
`include "bbas_defs.vh"
`define CHK(n, g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected %s expected %0h seen %0h", n, e, g); end end
module tb;
    logic mclk_i = 0, sys_rst_i = 1, exec_i = 0, cond_i = 0, res_hi_we_o, done_o, carry_flag_o;
    logic [9:0] func_i = 0;
    logic [15:0] op_a_lo_i = 0, op_a_hi_i = 0, op_b_lo_i = 0, op_b_hi_i = 0, res_lo_o, res_hi_o, st_lo, st_hi;
    int err_count = 0, comparisons = 0, cycles = 0;
    bbas_unit dut (.mclk_i, .sys_rst_i, .exec_i, .cond_i, .func_i, .op_a_lo_i, .op_a_hi_i, .op_b_lo_i,
        .op_b_hi_i, .res_lo_o, .res_hi_o, .res_hi_we_o, .done_o, .carry_flag_o);
    bbas_store store (.mclk_i, .done_i(done_o), .we_hi_i(res_hi_we_o), .lo_i(res_lo_o), .hi_i(res_hi_o),
        .word_r_o(st_lo), .word_r1_o(st_hi));
    initial begin
        forever #25 mclk_i = ~mclk_i;
    end
    task wrap_up;
        if (err_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Hang guard; the whole run needs under a hundred cycles
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 500) begin
            err_count++;
            wrap_up;
        end
    end
    task issue(input [9:0] f, input [31:0] a, input [31:0] b, input c);
        @(posedge mclk_i);
        exec_i <= 1;
        cond_i <= c;
        func_i <= f;
        {op_a_hi_i, op_a_lo_i} <= a;
        {op_b_hi_i, op_b_lo_i} <= b;
        @(posedge mclk_i);
        exec_i <= 0;
        #1;
    endtask
    task op(input [9:0] f, input [31:0] a, input [31:0] b, input [31:0] er, input ecy);
        issue(f, a, b, 1);
        `CHK("done", done_o, 1'b1)
        `CHK("result", {res_hi_o, res_lo_o}, er)
        `CHK("carry", carry_flag_o, ecy)
        `CHK("high enable", res_hi_we_o, f[0])
    endtask
    task t_bin;
        op(`BBAS_FC_ADD, 32'h0000FFFF, 32'h1, 32'h0, 1);
        op(`BBAS_FC_ADD_CARRY, 32'h1, 32'h2, 32'h4, 0);
        op(`BBAS_FC_ADD_DOUBLE, 32'hFFFFFFFF, 32'h1, 32'h0, 1);
        op(`BBAS_FC_BIN_ADD_CARRY_DOUBLE, 32'h0000FFFF, 32'h0, 32'h00010000, 0);
        op(`BBAS_FC_SUB, 32'h1, 32'h2, 32'h0000FFFF, 1);
        op(`BBAS_FC_SUB_CARRY, 32'h5, 32'h3, 32'h1, 0);
        op(`BBAS_FC_SUB_DOUBLE, 32'h0, 32'h1, 32'hFFFFFFFF, 1);
        op(`BBAS_FC_BIN_SUB_CARRY_DOUBLE, 32'h00010000, 32'h0, 32'h0000FFFF, 0);
    endtask
    task t_bcd;
        op(`BBAS_FC_DEC_ADD, 32'h9999, 32'h1, 32'h0, 1);
        op(`BBAS_FC_DEC_ADD_CARRY_SINGLE, 32'h0123, 32'h0456, 32'h0580, 0);
        op(`BBAS_FC_DEC_ADD_DOUBLE, 32'h99999999, 32'h1, 32'h0, 1);
        op(`BBAS_FC_DEC_ADD_CARRY_DOUBLE, 32'h9999, 32'h0, 32'h00010000, 0);
        op(`BBAS_FC_DEC_SUB, 32'h0, 32'h1, 32'h9999, 1);
        op(`BBAS_FC_DEC_SUB_CARRY_SINGLE, 32'h0100, 32'h1, 32'h0098, 0);
        op(`BBAS_FC_DEC_SUB_DOUBLE, 32'h0, 32'h1, 32'h99999999, 1);
        op(`BBAS_FC_DEC_SUB_CARRY_DOUBLE, 32'h00010000, 32'h0, 32'h00009999, 0);
        @(posedge mclk_i);
        #1;
        `CHK("stored pair", {st_hi, st_lo}, 32'h00009999)
    endtask
    // A false condition and the unused code 408 must both leave everything alone
    task t_refuse;
        issue(`BBAS_FC_ADD, 32'hFFFF, 32'h1, 0);
        `CHK("done off", done_o, 1'b0)
        issue(10'h198, 32'hFFFF, 32'h1, 1);
        `CHK("held result", {res_hi_o, res_lo_o, carry_flag_o}, 33'h000013332)
    endtask
    task t_b2b;
        @(posedge mclk_i);
        exec_i <= 1;
        cond_i <= 1;
        func_i <= `BBAS_FC_ADD;
        op_a_lo_i <= 16'hFFFF;
        op_b_lo_i <= 16'h0001;
        @(posedge mclk_i);
        func_i <= `BBAS_FC_ADD_CARRY;
        op_a_lo_i <= 16'h0001;
        #1;
        `CHK("chain carry", carry_flag_o, 1'b1)
        @(posedge mclk_i);
        exec_i <= 0;
        #1;
        `CHK("chain sum", {done_o, carry_flag_o, res_lo_o}, 18'h20003)
        @(posedge mclk_i);
        #1;
        `CHK("done pulse", done_o, 1'b0)
    endtask
    initial begin
        repeat (2) @(posedge mclk_i);
        sys_rst_i <= 0;
        t_bin;
        t_bcd;
        t_refuse;
        t_b2b;
        wrap_up;
    end
endmodule
